// ### tb/core_model.sv
// Model of the core sequencer that faces the interrupt controller.
// Assumes one machine cycle every two clocks and return and hazard commands from the bench.
`timescale 1ns/10ps

module core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bench commands
	input wire logic do_return,
	input wire logic hold_write,
	// Controller side
	input wire logic forced_long_call,
	input wire logic call_active,
	output logic machine_cycle,
	output logic instr_boundary,
	output logic return_from_interrupt,
	output logic sfr_write_irq_regs,
	output logic [3:0] call_len
);
	logic phase;

	assign instr_boundary = 1'b1;
	assign sfr_write_irq_regs = hold_write;

	// The return stays up until a machine cycle has seen it, so it is never lost.
	always_ff @(posedge clk) begin
		if (rst) begin
			phase <= 1'b0;
			machine_cycle <= 1'b0;
			return_from_interrupt <= 1'b0;
			call_len <= 4'h0;
		end else begin
			phase <= ~phase;
			machine_cycle <= phase;
			if (do_return)
				return_from_interrupt <= 1'b1;
			else if (machine_cycle)
				return_from_interrupt <= 1'b0;
			if (call_active && machine_cycle)
				call_len <= (forced_long_call ? 4'h0 : call_len) + 4'h1;
			else if (forced_long_call)
				call_len <= 4'h0;
		end
	end
endmodule // core_model

// ### tb/irq_ctrl_tb.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model is compiled before this file.
`timescale 1ns/10ps
`include "irq_ctrl_consts.svh"

module irq_ctrl_tb
	import irq_ctrl_pkg::*;
;
	typedef struct packed {
		logic [11:0] ofs;
		logic [7:0] wd;
		logic [7:0] rd;
	} reg_row_t;
	typedef struct packed {
		source_t src;
		logic [15:0] vec;
		logic [11:0] fofs;
		logic [7:0] fset;
		logic [7:0] fclr;
	} src_row_t;

	logic clk, rst, psel, penable, pwrite, do_return, hold_write, pready, pslverr;
	logic machine_cycle, instr_boundary, return_from_interrupt, sfr_write_irq_regs;
	logic forced_long_call, call_active, ack0, ack1;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] call_vector;
	logic [3:0] call_len;
	logic [11:0] req;
	int fails, samples_checked;
	localparam logic [11:0] SERIAL = 12'h102;
	reg_row_t reg_rows [8] = '{'{`OFS_ENABLE_FIRST, 8'hFF, 8'h9F}, '{`OFS_ENABLE_SECOND, 8'hFF, 8'h3E},
		'{`OFS_ENABLE_THIRD, 8'hFF, 8'h01}, '{`OFS_PRIO_LOW, 8'hFF, 8'h3F},
		'{`OFS_PRIO_HIGH, 8'hFF, 8'h3F}, '{`OFS_TIMER_FLAGS, 8'h05, 8'h05},
		'{`OFS_EXT_FLAGS, 8'hC1, 8'h00}, '{12'h024, 8'hFF, 8'h00}};
	src_row_t src_rows [11] = '{'{SRC_EXT0, 16'h0003, `OFS_TIMER_FLAGS, 8'h07, 8'h05},
		'{SRC_SER1, 16'h0083, `OFS_TIMER_FLAGS, 8'h05, 8'h05},
		'{SRC_TMR0, 16'h000B, `OFS_TIMER_FLAGS, 8'h25, 8'h05},
		'{SRC_EXT2, 16'h004B, `OFS_EXT_FLAGS, 8'h02, 8'h00},
		'{SRC_EXT1, 16'h0013, `OFS_TIMER_FLAGS, 8'h0D, 8'h05},
		'{SRC_EXT3, 16'h0053, `OFS_EXT_FLAGS, 8'h04, 8'h00},
		'{SRC_TMR1, 16'h001B, `OFS_TIMER_FLAGS, 8'h85, 8'h05},
		'{SRC_EXT4, 16'h005B, `OFS_EXT_FLAGS, 8'h08, 8'h00},
		'{SRC_SER0, 16'h0023, `OFS_TIMER_FLAGS, 8'h05, 8'h05},
		'{SRC_EXT5, 16'h0063, `OFS_EXT_FLAGS, 8'h10, 8'h00},
		'{SRC_EXT6, 16'h006B, `OFS_EXT_FLAGS, 8'h20, 8'h20}};

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Edge inputs get a one-clock pulse; the request lines of ext0 and ext1 idle high.
	irq_ctrl i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.machine_cycle(machine_cycle), .instr_boundary(instr_boundary),
		.return_from_interrupt(return_from_interrupt), .sfr_write_irq_regs(sfr_write_irq_regs),
		.forced_long_call(forced_long_call), .call_vector(call_vector),
		.call_active(call_active), .timer0_service_ack(ack0), .timer1_service_ack(ack1),
		.timer0_overflow(req[SRC_TMR0]), .timer1_overflow(req[SRC_TMR1]),
		.serial0_request(req[SRC_SER0]), .serial1_request(req[SRC_SER1]),
		.dio_high_req(~req[SRC_EXT0]), .dio_low_req(~req[SRC_EXT1]),
		.comparator_fall_req(req[SRC_EXT2]), .compute_busy(req[SRC_EXT3]),
		.comparator_rise_req(req[SRC_EXT4]), .eeprom_busy(req[SRC_EXT5]),
		.rtc_second_event(req[SRC_EXT6]), .transfer_busy_event(req[11]));

	core_model i_core (.clk(clk), .rst(rst), .do_return(do_return), .hold_write(hold_write),
		.forced_long_call(forced_long_call), .call_active(call_active),
		.machine_cycle(machine_cycle), .instr_boundary(instr_boundary),
		.return_from_interrupt(return_from_interrupt),
		.sfr_write_irq_regs(sfr_write_irq_regs), .call_len(call_len));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("Mismatches %0d, comparisons %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic timeout();
		fails++;
		$display("[FAIL] %0t wait ran out", $time);
		end_sim();
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16)
			timeout();
		q = prdata;
		chk({31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic raise(input logic [11:0] m);
		@(posedge clk);
		req <= m;
		@(posedge clk);
		req <= m & SERIAL;
	endtask

	task automatic quiet(input int k);
		repeat (k) begin
			@(negedge clk);
			chk({31'h0, forced_long_call}, 32'h0);
		end
	endtask

	task automatic wait_call(input logic [15:0] v, input logic [1:0] ak);
		logic [1:0] a;
		int n;
		a = 2'b00;
		for (n = 0; n < 80; n++) begin
			@(negedge clk);
			a = a | {ack1, ack0};
			if (forced_long_call === 1'b1)
				break;
		end
		if (n == 80)
			timeout();
		chk({16'h0, call_vector}, {16'h0, v});
		chk({30'h0, a}, {30'h0, ak});
		@(posedge clk);
		req <= 12'h0;
		for (n = 0; n < 80 && call_active === 1'b1; n++)
			@(negedge clk);
		if (n == 80)
			timeout();
		chk({28'h0, call_len}, 32'h6);
	endtask

	task automatic ret();
		int n;
		@(posedge clk);
		do_return <= 1'b1;
		@(posedge clk);
		do_return <= 1'b0;
		@(negedge clk);
		for (n = 0; n < 20 && return_from_interrupt === 1'b1; n++)
			@(negedge clk);
		if (n == 20)
			timeout();
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		{rst, psel, penable, pwrite, do_return, hold_write} = 6'b100000;
		paddr = 12'h0;
		pwdata = 32'h0;
		req = 12'h0;
		fails = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (reg_rows[i]) begin
			apb(1'b0, reg_rows[i].ofs, 32'h0);
			chk(q, 32'h0);
			apb(1'b1, reg_rows[i].ofs, {24'h0, reg_rows[i].wd});
			apb(1'b0, reg_rows[i].ofs, 32'h0);
			chk(q, {24'h0, reg_rows[i].rd});
			apb(1'b1, reg_rows[i].ofs, 32'h0);
		end
		apb(1'b1, `OFS_ENABLE_SECOND, 32'h3E);
		apb(1'b1, `OFS_ENABLE_THIRD, 32'h01);
		apb(1'b1, `OFS_TIMER_FLAGS, 32'h05);
		apb(1'b1, `OFS_EVENT_CTRL, 32'h01);
		foreach (src_rows[i]) begin
			apb(1'b1, `OFS_ENABLE_FIRST, 32'h1F);
			raise(12'h1 << src_rows[i].src);
			quiet(8);
			apb(1'b0, src_rows[i].fofs, 32'h0);
			chk(q, {24'h0, src_rows[i].fset});
			apb(1'b1, `OFS_ENABLE_FIRST, 32'h9F);
			wait_call(src_rows[i].vec, {src_rows[i].src == SRC_TMR1, src_rows[i].src == SRC_TMR0});
			apb(1'b0, src_rows[i].fofs, 32'h0);
			chk(q, {24'h0, src_rows[i].fclr});
			apb(1'b1, src_rows[i].fofs, {24'h0, src_rows[i].fclr & 8'hDF});
			ret();
			apb(1'b0, `OFS_CORE_STATUS, 32'h0);
			chk(q, {28'h0, src_rows[i].src});
		end
		// The shared input only sees a new edge once both event flags are cleared.
		apb(1'b0, `OFS_EVENT_CTRL, 32'h0);
		chk(q, 32'h05);
		apb(1'b1, `OFS_EVENT_CTRL, 32'h03);
		apb(1'b1, `OFS_EXT_FLAGS, 32'h0);
		apb(1'b0, `OFS_EXT_FLAGS, 32'h0);
		chk(q, 32'h0);
		raise(12'h800);
		wait_call(16'h006B, 2'b00);
		apb(1'b1, `OFS_EVENT_CTRL, 32'h03);
		apb(1'b1, `OFS_EXT_FLAGS, 32'h0);
		ret();
		raise((12'h1 << SRC_TMR1) | (12'h1 << SRC_EXT4));
		wait_call(16'h001B, 2'b10);
		quiet(20);
		ret();
		wait_call(16'h005B, 2'b00);
		ret();
		apb(1'b1, `OFS_PRIO_LOW, 32'h10);
		apb(1'b1, `OFS_PRIO_HIGH, 32'h10);
		raise(12'h1 << SRC_TMR0);
		wait_call(16'h000B, 2'b01);
		raise(12'h1 << SRC_EXT5);
		wait_call(16'h0063, 2'b00);
		raise(12'h1 << SRC_TMR1);
		quiet(20);
		ret();
		quiet(20);
		ret();
		wait_call(16'h001B, 2'b10);
		ret();
		apb(1'b0, `OFS_CORE_STATUS, 32'h0);
		chk(q & 32'hF0, 32'h0);
		@(posedge clk);
		hold_write <= 1'b1;
		raise(12'h1 << SRC_TMR0);
		quiet(20);
		@(posedge clk);
		hold_write <= 1'b0;
		wait_call(16'h000B, 2'b01);
		ret();
		end_sim();
	end
endmodule // irq_ctrl_tb

// ### verilog/irq_ctrl.sv
// Interrupt controller for an 8-bit core: enables, flags, priority, vectoring.
// Assumes the core gives a machine-cycle strobe, reports each instruction
// boundary and return, and runs the forced call when told to.
//
// Functional notes
// - Eleven sources, four priority levels.
// - Only strictly higher priority preempts active service.
// - Return ends active level; core resumes.
// - Flags set even when source disabled.
// - Flags sampled each machine cycle, then polled.
// - Recognised request forces call to its vector.
// - Defer during return or enable/priority writes.
// - Latency: one detect plus six call cycles.
// - Global enable at first register bit 7.
// - First register holds five individual enables.
// - Second register enables inputs two to six.
// - Third register bit 0 enables serial 1.
// - Timer flags register field layout.
// - Type select picks falling edge or level.
// - Request register holds inputs two-six flags.
// - Timer flags cleared by core acknowledge.
// - Inputs 0-5 auto clear; 6 software.
// - External inputs wired to their peripherals.
// - Inputs 2-3 falling; 5 inverted.
// - Input 6 is OR of two events.
// - Two priority bits per group form level.
// - Fixed polling order breaks ties.
// - Fixed vector addresses per source.
`timescale 1ns/10ps
`include "irq_ctrl_consts.svh"

module irq_ctrl
	import irq_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core sequencer
	input wire logic machine_cycle,
	input wire logic instr_boundary,
	input wire logic return_from_interrupt,
	input wire logic sfr_write_irq_regs,
	output logic forced_long_call,
	output logic [15:0] call_vector,
	output logic call_active,
	output logic timer0_service_ack,
	output logic timer1_service_ack,
	// Peripheral request lines
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic serial0_request,
	input wire logic serial1_request,
	input wire logic dio_high_req,
	input wire logic dio_low_req,
	input wire logic comparator_fall_req,
	input wire logic compute_busy,
	input wire logic comparator_rise_req,
	input wire logic eeprom_busy,
	input wire logic rtc_second_event,
	input wire logic transfer_busy_event
);

	state_t cur;
	state_t next_cur;

	// --------------------------------------------------------------------
	// Helper functions
	// --------------------------------------------------------------------
	function automatic logic [1:0] level_of(input logic [3:0] src, input logic [7:0] lo,
			input logic [7:0] hi);
		logic [2:0] grp;
		grp = 3'h0;
		case (src)
			SRC_EXT0, SRC_SER1: grp = 3'h0;
			SRC_TMR0, SRC_EXT2: grp = 3'h1;
			SRC_EXT1, SRC_EXT3: grp = 3'h2;
			SRC_TMR1, SRC_EXT4: grp = 3'h3;
			SRC_SER0, SRC_EXT5: grp = 3'h4;
			default: grp = 3'h5;
		endcase
		level_of = {hi[grp], lo[grp]};
	endfunction

	function automatic logic [15:0] vector_of(input logic [3:0] src);
		case (src)
			SRC_EXT0: vector_of = `VEC_EXT0;
			SRC_TMR0: vector_of = `VEC_TMR0;
			SRC_EXT1: vector_of = `VEC_EXT1;
			SRC_TMR1: vector_of = `VEC_TMR1;
			SRC_SER0: vector_of = `VEC_SER0;
			SRC_SER1: vector_of = `VEC_SER1;
			SRC_EXT2: vector_of = `VEC_EXT2;
			SRC_EXT3: vector_of = 16'(`VEC_EXT2 + `VEC_EXT_STEP);
			SRC_EXT4: vector_of = 16'(`VEC_EXT2 + 2 * `VEC_EXT_STEP);
			SRC_EXT5: vector_of = 16'(`VEC_EXT2 + 3 * `VEC_EXT_STEP);
			default: vector_of = 16'(`VEC_EXT2 + 4 * `VEC_EXT_STEP);
		endcase
	endfunction

	function automatic logic [1:0] top_level(input logic [3:0] act);
		if (act[3])
			top_level = 2'h3;
		else if (act[2])
			top_level = 2'h2;
		else if (act[1])
			top_level = 2'h1;
		else
			top_level = 2'h0;
	endfunction

	// --------------------------------------------------------------------
	// Combinational next state
	// --------------------------------------------------------------------
	logic apb_write;
	logic apb_read;
	logic [10:0] raw;
	logic [10:0] enabled;
	logic event_or;
	logic found;
	logic [3:0] best_src;
	logic [1:0] best_lvl;
	logic [1:0] lvl;

	assign apb_write = psel && penable && pwrite;
	assign apb_read = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = cur.prdata;
	assign call_vector = cur.vector;
	assign forced_long_call = cur.call_req;
	assign call_active = cur.seq_is_call;

	always_comb begin
		next_cur = cur;
		timer0_service_ack = 1'b0;
		timer1_service_ack = 1'b0;
		found = 1'b0;
		best_src = 4'h0;
		best_lvl = 2'h0;
		lvl = 2'h0;
		next_cur.call_req = 1'b0;

		// Edge history for external inputs; 4 to 6 see rising edges of the
		// inverted or direct signals as wired.
		next_cur.ext0_last = dio_high_req;
		next_cur.ext1_last = dio_low_req;
		next_cur.ext_last = {event_or, !eeprom_busy, comparator_rise_req, compute_busy,
			comparator_fall_req};

		// Flags set regardless of enables.
		if (timer1_overflow)
			next_cur.timer_flags[`BIT_TMR1_FLAG] = 1'b1;
		if (timer0_overflow)
			next_cur.timer_flags[`BIT_TMR0_FLAG] = 1'b1;
		// Type select high means falling edge, low means low level.
		if (cur.timer_flags[`BIT_EXT0_TYPE] ? (cur.ext0_last && !dio_high_req) : !dio_high_req)
			next_cur.timer_flags[`BIT_EXT0_FLAG] = 1'b1;
		if (cur.timer_flags[`BIT_EXT1_TYPE] ? (cur.ext1_last && !dio_low_req) : !dio_low_req)
			next_cur.timer_flags[`BIT_EXT1_FLAG] = 1'b1;
		// Inputs 2 and 3 falling; 4 and 6 rising; 5 inverted source rising.
		if (cur.ext_last[2] && !comparator_fall_req)
			next_cur.ext_flags[1] = 1'b1;
		if (cur.ext_last[3] && !compute_busy)
			next_cur.ext_flags[2] = 1'b1;
		if (!cur.ext_last[4] && comparator_rise_req)
			next_cur.ext_flags[3] = 1'b1;
		if (!cur.ext_last[5] && eeprom_busy == 1'b0)
			next_cur.ext_flags[4] = 1'b1;
		if (!cur.ext_last[6] && event_or)
			next_cur.ext_flags[5] = 1'b1;
		if (rtc_second_event)
			next_cur.event_ctrl[`BIT_RTC_FLAG] = 1'b1;
		if (transfer_busy_event)
			next_cur.event_ctrl[`BIT_XFER_FLAG] = 1'b1;

		// Register writes; a hardware set above wins over a software clear only where the flag was clear before.
		if (apb_write) begin
			case (paddr)
				`OFS_ENABLE_FIRST: next_cur.enable_first = pwdata[7:0] & `MASK_ENABLE_FIRST;
				`OFS_ENABLE_SECOND: next_cur.enable_second = pwdata[7:0] & `MASK_ENABLE_SECOND;
				`OFS_ENABLE_THIRD: next_cur.enable_third = pwdata[7:0] & `MASK_ENABLE_THIRD;
				`OFS_TIMER_FLAGS:
					next_cur.timer_flags = (pwdata[7:0] & `MASK_TIMER_FLAGS) |
						(next_cur.timer_flags & ~cur.timer_flags);
				`OFS_EXT_FLAGS:
					next_cur.ext_flags = (pwdata[7:0] & `MASK_EXT_FLAGS) |
						(next_cur.ext_flags & ~cur.ext_flags);
				`OFS_PRIO_LOW: next_cur.prio_low = pwdata[7:0] & `MASK_PRIO;
				`OFS_PRIO_HIGH: next_cur.prio_high = pwdata[7:0] & `MASK_PRIO;
				`OFS_EVENT_CTRL:
					next_cur.event_ctrl = 4'((pwdata[7:0] & `MASK_EVENT_CTRL) |
						{4'h0, next_cur.event_ctrl & ~cur.event_ctrl});
				default: ;
			endcase
		end
		if (apb_read) begin
			case (paddr)
				`OFS_ENABLE_FIRST: next_cur.prdata = {24'h0, cur.enable_first};
				`OFS_ENABLE_SECOND: next_cur.prdata = {24'h0, cur.enable_second};
				`OFS_ENABLE_THIRD: next_cur.prdata = {24'h0, cur.enable_third};
				`OFS_TIMER_FLAGS: next_cur.prdata = {24'h0, cur.timer_flags};
				`OFS_EXT_FLAGS: next_cur.prdata = {24'h0, cur.ext_flags};
				`OFS_PRIO_LOW: next_cur.prdata = {24'h0, cur.prio_low};
				`OFS_PRIO_HIGH: next_cur.prdata = {24'h0, cur.prio_high};
				`OFS_EVENT_CTRL: next_cur.prdata = {28'h0, cur.event_ctrl};
				`OFS_CORE_STATUS:
					next_cur.prdata = {24'h0, cur.active_levels, cur.call_src};
				default: next_cur.prdata = 32'h0000_0000;
			endcase
		end

		// Sample every flag once per machine cycle.
		if (machine_cycle)
			next_cur.sample = raw;

		// Poll samples in fixed order, keep the first of the highest level.
		for (int i = 0; i < `NUM_SOURCES; i++) begin
			lvl = level_of(4'(i), cur.prio_low, cur.prio_high);
			if (enabled[i] && (!found || lvl > best_lvl)) begin
				found = 1'b1;
				best_src = 4'(i);
				best_lvl = lvl;
			end
		end

		case (cur.seq_is_call)
			1'b0: begin
				// Only strictly higher than any level in service.
				if (found && machine_cycle && instr_boundary
						&& !return_from_interrupt && !sfr_write_irq_regs
						&& (cur.active_levels == 4'h0
						|| best_lvl > top_level(cur.active_levels))) begin
					next_cur.seq_is_call = 1'b1;
					next_cur.call_req = 1'b1;
					next_cur.call_src = best_src;
					next_cur.vector = vector_of(best_src);
					next_cur.call_count = `CALL_CYCLES;
					next_cur.active_levels[best_lvl] = 1'b1;
					// Auto clear on entry; input 6 left to software.
					case (best_src)
						SRC_TMR0: begin
							// A new overflow in the entry cycle must not be lost.
							timer0_service_ack = 1'b1;
							next_cur.timer_flags[`BIT_TMR0_FLAG] = timer0_overflow;
						end
						SRC_TMR1: begin
							timer1_service_ack = 1'b1;
							next_cur.timer_flags[`BIT_TMR1_FLAG] = timer1_overflow;
						end
						SRC_EXT0: next_cur.timer_flags[`BIT_EXT0_FLAG] = 1'b0;
						SRC_EXT1: next_cur.timer_flags[`BIT_EXT1_FLAG] = 1'b0;
						SRC_EXT2: next_cur.ext_flags[1] = 1'b0;
						SRC_EXT3: next_cur.ext_flags[2] = 1'b0;
						SRC_EXT4: next_cur.ext_flags[3] = 1'b0;
						SRC_EXT5: next_cur.ext_flags[4] = 1'b0;
						default: ;
					endcase
					next_cur.sample[best_src] = 1'b0;
				end else if (return_from_interrupt && machine_cycle
						&& cur.active_levels != 4'h0) begin
					// Retire the highest level in service.
					next_cur.active_levels[top_level(cur.active_levels)] = 1'b0;
				end
			end
			default: begin
				if (machine_cycle) begin
					next_cur.call_count = 3'(cur.call_count - 3'h1);
					if (cur.call_count == 3'h1)
						next_cur.seq_is_call = 1'b0;
				end
			end
		endcase
	end

	// Raw requests in polling order and the enabled view of the samples.
	assign event_or = (cur.event_ctrl[`BIT_RTC_FLAG] && cur.event_ctrl[`BIT_RTC_EN])
		|| (cur.event_ctrl[`BIT_XFER_FLAG] && cur.event_ctrl[`BIT_XFER_EN]);
	assign raw = {cur.ext_flags[5], cur.ext_flags[4], serial0_request,
		cur.ext_flags[3], cur.timer_flags[`BIT_TMR1_FLAG], cur.ext_flags[2],
		cur.timer_flags[`BIT_EXT1_FLAG], cur.ext_flags[1],
		cur.timer_flags[`BIT_TMR0_FLAG], serial1_request, cur.timer_flags[`BIT_EXT0_FLAG]};
	assign enabled = cur.sample & {11{cur.enable_first[`BIT_GLOBAL_EN]}} & {
		cur.enable_second[5], cur.enable_second[4], cur.enable_first[`BIT_SER0_EN],
		cur.enable_second[3], cur.enable_first[`BIT_TMR1_EN], cur.enable_second[2],
		cur.enable_first[`BIT_EXT1_EN], cur.enable_second[1],
		cur.enable_first[`BIT_TMR0_EN], cur.enable_third[`BIT_SER1_EN],
		cur.enable_first[`BIT_EXT0_EN]};

	// --------------------------------------------------------------------
	// State register
	// --------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			// The inverted busy line idles high, so its history starts high to
			// avoid a false edge right after reset.
			cur <= '0;
			cur.ext_last[5] <= 1'b1;
		end else
			cur <= next_cur;
	end

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	a_global_gate: assert property (@(posedge clk) disable iff (rst)
		!cur.enable_first[`BIT_GLOBAL_EN] && !cur.seq_is_call |=> !forced_long_call)
		else $error("call taken with global enable off");
	a_defer_write: assert property (@(posedge clk) disable iff (rst)
		sfr_write_irq_regs && !cur.seq_is_call |=> !forced_long_call)
		else $error("call taken during enable or priority write");
	a_call_vector: assert property (@(posedge clk) disable iff (rst)
		forced_long_call |-> call_vector == vector_of(cur.call_src))
		else $error("vector does not match source");
	a_call_length: assert property (@(posedge clk) disable iff (rst)
		forced_long_call |-> call_active && cur.call_count == `CALL_CYCLES)
		else $error("call sequence not active at start");
	a_timer_ack: assert property (@(posedge clk) disable iff (rst)
		timer0_service_ack |=> !cur.timer_flags[`BIT_TMR0_FLAG] || $past(timer0_overflow))
		else $error("timer 0 flag not cleared on acknowledge");
	a_preempt_level: assert property (@(posedge clk) disable iff (rst)
		forced_long_call |-> $countones(cur.active_levels) > $countones($past(cur.active_levels)))
		else $error("call without a new higher level");
	a_return_level: assert property (@(posedge clk) disable iff (rst)
		return_from_interrupt && machine_cycle && !cur.seq_is_call && cur.active_levels != 4'h0
		|=> $countones(cur.active_levels) < $countones($past(cur.active_levels)))
		else $error("return did not retire a level");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		timer1_overflow |=> cur.timer_flags[`BIT_TMR1_FLAG])
		else $error("timer 1 flag not set on overflow");

endmodule // irq_ctrl

// ### verilog/irq_ctrl_consts.svh
// Constants for the interrupt controller: register offsets, field positions,
// reset values, vectors and timing counts.
// Assumes inclusion by bare name from the package and the design file.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define OFS_ENABLE_FIRST 12'h000
`define OFS_ENABLE_SECOND 12'h004
`define OFS_ENABLE_THIRD 12'h008
`define OFS_TIMER_FLAGS 12'h00C
`define OFS_EXT_FLAGS 12'h010
`define OFS_PRIO_LOW 12'h014
`define OFS_PRIO_HIGH 12'h018
`define OFS_EVENT_CTRL 12'h01C
`define OFS_CORE_STATUS 12'h020

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_GLOBAL_EN 7
`define BIT_SER0_EN 4
`define BIT_TMR1_EN 3
`define BIT_EXT1_EN 2
`define BIT_TMR0_EN 1
`define BIT_EXT0_EN 0
`define BIT_SER1_EN 0
`define BIT_TMR1_FLAG 7
`define BIT_TMR0_FLAG 5
`define BIT_EXT1_FLAG 3
`define BIT_EXT1_TYPE 2
`define BIT_EXT0_FLAG 1
`define BIT_EXT0_TYPE 0
`define BIT_RTC_EN 0
`define BIT_XFER_EN 1
`define BIT_RTC_FLAG 2
`define BIT_XFER_FLAG 3

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define MASK_ENABLE_FIRST 8'h9F
`define MASK_ENABLE_SECOND 8'h3E
`define MASK_ENABLE_THIRD 8'h01
`define MASK_TIMER_FLAGS 8'hAF
`define MASK_EXT_FLAGS 8'h3E
`define MASK_PRIO 8'h3F
`define MASK_EVENT_CTRL 8'h0F
`define RESET_BYTE 8'h00

// ----------------------------------------------------------------------------
// Vectors and timing
// ----------------------------------------------------------------------------
`define VEC_EXT0 16'h0003
`define VEC_TMR0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TMR1 16'h001B
`define VEC_SER0 16'h0023
`define VEC_SER1 16'h0083
`define VEC_EXT2 16'h004B
`define VEC_EXT_STEP 16'h0008
`define CALL_CYCLES 3'h6
`define NUM_SOURCES 11
`define NUM_LEVELS 4

`endif

// ### verilog/irq_ctrl_pkg.sv
// Types shared by the interrupt controller.
// Assumes the constants header is on the include path.
package irq_ctrl_pkg;
`include "irq_ctrl_consts.svh"

	// Source indices in fixed polling order.
	typedef enum logic [3:0] {
		SRC_EXT0, SRC_SER1, SRC_TMR0, SRC_EXT2, SRC_EXT1, SRC_EXT3,
		SRC_TMR1, SRC_EXT4, SRC_SER0, SRC_EXT5, SRC_EXT6
	} source_t;

	typedef enum {ST_IDLE, ST_CALL} seq_t;

	typedef struct packed {
		logic [7:0] enable_first;
		logic [7:0] enable_second;
		logic [7:0] enable_third;
		logic [7:0] timer_flags;
		logic [7:0] ext_flags;
		logic [7:0] prio_low;
		logic [7:0] prio_high;
		logic [3:0] event_ctrl;
		logic ext0_last;
		logic ext1_last;
		logic [6:2] ext_last;
		logic [10:0] sample;
		logic [3:0] active_levels;
		logic [2:0] call_count;
		logic [3:0] call_src;
		logic [15:0] vector;
		logic call_req;
		logic [31:0] prdata;
		logic seq_is_call;
	} state_t;
endpackage
